/* core/dtc_pkg.sv */
// constants, register map and bus carriers of the debug trigger and capture status block
// Behaviour
// - trigger control readable; writable only while disarmed
// - force type: comparator match triggers directly
// - tag type: trigger only when opcode executes; range modes 7 and 8 ignore it
// - bit 6 picks end or begin trace
// - event-only modes always act as begin trace
// - modes 0 to 2: A, A or B, A then B
// - mode 3 stores on B; mode 4 after A
// - modes 5, 6: address A with data B
// - mode 7 inside range, mode 8 outside range
// - modes 9 to 15 never trigger
// - A flag clears at run start, sticks on match
// - B flag clears at run start, sticks on match
// - armed flag mirrors arm control under enable
// - run ends on full begin or end trigger
// - writing arm or enable zero ends run
// - valid count clears at start, reports words
// - fifo reads never decrement the valid count
// - run status register is read only
// - low byte read advances fifo, high does not; the code advances it only while disarmed
// - enable stays zero while device is secured
package dtc_pkg;
  localparam logic [3:0] ADDR_CONTROL  = 4'h0;
  localparam logic [3:0] ADDR_TRIGGER  = 4'h4;
  localparam logic [3:0] ADDR_STATUS   = 4'h8;
  localparam logic [3:0] ADDR_FIFO_LOW = 4'hC;
  localparam logic [3:0] ADDR_FIFO_HI  = 4'h0;

  localparam int BIT_ENABLE   = 7;
  localparam int BIT_ARM      = 6;
  localparam int BIT_TYPE     = 7;
  localparam int BIT_BEGIN    = 6;
  localparam int BIT_A_FLAG   = 7;
  localparam int BIT_B_FLAG   = 6;
  localparam int BIT_ARM_FLAG = 5;

  localparam logic [7:0] TRIGGER_WRITE_MASK = 8'hCF;
  localparam logic [7:0] CONTROL_RESET      = 8'h00;
  localparam logic [7:0] TRIGGER_RESET      = 8'h00;
  localparam logic [3:0] FIFO_DEPTH         = 4'h8;
  localparam logic [3:0] COUNT_RESET        = 4'h0;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [3:0] {
    MODE_A_ONLY     = 4'h0,
    MODE_A_OR_B     = 4'h1,
    MODE_A_THEN_B   = 4'h2,
    MODE_EVENT_B    = 4'h3,
    MODE_A_EVENT_B  = 4'h4,
    MODE_A_AND_B    = 4'h5,
    MODE_A_AND_NOTB = 4'h6,
    MODE_INSIDE     = 4'h7,
    MODE_OUTSIDE    = 4'h8
  } dtc_mode_type;

  // one bus cycle seen by the comparators
  typedef struct packed {
    logic        valid;
    logic [15:0] addr;
    logic [7:0]  data;
    logic        opcode_fetch;
  } dtc_bus_type;

  typedef struct packed {
    logic [7:0] control;
    logic [7:0] trigger;
    logic [7:0] status;
  } dtc_regs_type;
endpackage

/* core/dtc_tag_track.sv */
// opcode tracking: holds a tag match until the tagged opcode executes or is discarded
`timescale 1ns/10ps
module dtc_tag_track (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic clear,
  input  wire logic tag_a,
  input  wire logic tag_b,
  input  wire logic exec_valid,
  input  wire logic exec_taken,
  output logic      hit_a,
  output logic      hit_b
);
  logic pend_a;
  logic pend_b;

  // a tag waits on the fetched opcode; any execution event, taken or discarded, releases it
  always_ff @(posedge aclk) begin
    if (!aresetn || clear) begin
      pend_a <= 1'b0;
      pend_b <= 1'b0;
    end else if (exec_valid) begin
      pend_a <= tag_a;
      pend_b <= tag_b;
    end else begin
      pend_a <= pend_a | tag_a;
      pend_b <= pend_b | tag_b;
    end
  end

  assign hit_a = exec_valid & exec_taken & pend_a;
  assign hit_b = exec_valid & exec_taken & pend_b;
endmodule

/* core/dtc_fifo_count.sv */
// capture word counter: fill level of the eight word capture fifo
`timescale 1ns/10ps
module dtc_fifo_count (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       clear,
  input  wire logic       store,
  input  wire logic       circular,
  output logic [3:0]      count,
  output logic            full
);
  // reads of the fifo never reach this counter
  always_ff @(posedge aclk) begin
    if (!aresetn || clear) begin
      count <= dtc_pkg::COUNT_RESET;
    end else if (store && count != dtc_pkg::FIFO_DEPTH) begin
      count <= count + 4'h1;
    end
  end

  // a circular fill never reports full; it only saturates the count
  assign full = !circular && (count == dtc_pkg::FIFO_DEPTH);
endmodule

/* core/dtc_trigger.sv */
// debug trigger selection, run control and status with an axi4-lite register slave
//
// The address map and register access over AXI4-Lite were left to the implementer.
`timescale 1ns/10ps
module dtc_trigger (
  input  wire logic               aclk,
  input  wire logic               aresetn,
  input  wire logic [3:0]         s_axi_awaddr,
  input  wire logic               s_axi_awvalid,
  output logic                    s_axi_awready,
  input  wire logic [31:0]        s_axi_wdata,
  input  wire logic [3:0]         s_axi_wstrb,
  input  wire logic               s_axi_wvalid,
  output logic                    s_axi_wready,
  output logic [1:0]              s_axi_bresp,
  output logic                    s_axi_bvalid,
  input  wire logic               s_axi_bready,
  input  wire logic [3:0]         s_axi_araddr,
  input  wire logic               s_axi_arvalid,
  output logic                    s_axi_arready,
  output logic [31:0]             s_axi_rdata,
  output logic [1:0]              s_axi_rresp,
  output logic                    s_axi_rvalid,
  input  wire logic               s_axi_rready,
  input  wire dtc_pkg::dtc_bus_type bus,
  input  wire logic [15:0]        comp_a_value,
  input  wire logic [15:0]        comp_b_value,
  input  wire logic               exec_valid,
  input  wire logic               exec_taken,
  input  wire logic               secured,
  input  wire logic [15:0]        fifo_word,
  output logic                    fifo_store,
  output logic                    fifo_advance,
  output logic                    trigger_event,
  output logic                    run_active
);
  logic [7:0] control;
  logic [7:0] trigger;
  logic       flag_a;
  logic       flag_b;
  logic       armed;
  logic       seen_a;
  logic [3:0] valid_count;
  logic       fifo_full;
  logic       tag_hit_a;
  logic       tag_hit_b;

  // write channel bookkeeping
  logic        aw_held;
  logic        w_held;
  logic [3:0]  aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        do_write;
  logic        do_read;

  function automatic logic reg_mapped(input logic [3:0] addr);
    reg_mapped = (addr == dtc_pkg::ADDR_CONTROL) || (addr == dtc_pkg::ADDR_TRIGGER) ||
                 (addr == dtc_pkg::ADDR_STATUS)  || (addr == dtc_pkg::ADDR_FIFO_LOW);
  endfunction

  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  assign do_write      = aw_held && w_held && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      aw_addr <= 4'h0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held <= 1'b1;
      aw_addr <= s_axi_awaddr;
    end else if (do_write) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held <= 1'b1;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
    end else if (do_write) begin
      w_held <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= dtc_pkg::RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= reg_mapped(aw_addr) ? dtc_pkg::RESP_OKAY : dtc_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  logic ctl_write;
  logic trg_write;
  assign ctl_write = do_write && aw_addr == dtc_pkg::ADDR_CONTROL && w_strb[0];
  assign trg_write = do_write && aw_addr == dtc_pkg::ADDR_TRIGGER && w_strb[0];

  // ---- trigger decode ----
  logic         match_a_addr;
  logic         match_b_addr;
  logic         match_b_data;
  logic         in_range;
  logic         raw_a;
  logic         raw_b;
  logic         use_a;
  logic         use_b;
  logic         event_only;
  logic         begin_trace;
  logic         fire;
  logic         store_evt;
  dtc_pkg::dtc_mode_type mode;

  assign mode         = dtc_pkg::dtc_mode_type'(trigger[3:0]);
  assign match_a_addr = bus.valid && bus.addr == comp_a_value;
  assign match_b_addr = bus.valid && bus.addr == comp_b_value;
  assign match_b_data = bus.valid && bus.data == comp_b_value[7:0];
  assign in_range     = bus.valid && bus.addr >= comp_a_value && bus.addr <= comp_b_value;

  // comparator B watches data in the full modes, the address otherwise
  always_comb begin
    raw_a = match_a_addr;
    raw_b = match_b_addr;
    if (mode == dtc_pkg::MODE_A_AND_B || mode == dtc_pkg::MODE_A_AND_NOTB) begin
      raw_b = match_b_data;
    end
  end

  dtc_tag_track u_tag (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .clear      (!armed),
    .tag_a      (raw_a && bus.opcode_fetch),
    .tag_b      (raw_b && bus.opcode_fetch),
    .exec_valid (exec_valid),
    .exec_taken (exec_taken),
    .hit_a      (tag_hit_a),
    .hit_b      (tag_hit_b)
  );

  // tag type only passes matches whose opcode really ran
  assign use_a = trigger[dtc_pkg::BIT_TYPE] ? tag_hit_a : raw_a;
  assign use_b = trigger[dtc_pkg::BIT_TYPE] ? tag_hit_b : raw_b;

  assign event_only  = mode == dtc_pkg::MODE_EVENT_B || mode == dtc_pkg::MODE_A_EVENT_B;
  assign begin_trace = event_only || trigger[dtc_pkg::BIT_BEGIN];

  always_comb begin
    fire      = 1'b0;
    store_evt = 1'b0;
    case (mode)
      dtc_pkg::MODE_A_ONLY:     fire = use_a;
      dtc_pkg::MODE_A_OR_B:     fire = use_a || use_b;
      dtc_pkg::MODE_A_THEN_B:   fire = (seen_a || use_a) && use_b && seen_a;
      dtc_pkg::MODE_EVENT_B:    store_evt = use_b;
      dtc_pkg::MODE_A_EVENT_B:  store_evt = seen_a && use_b;
      dtc_pkg::MODE_A_AND_B:    fire = use_a && raw_b;
      dtc_pkg::MODE_A_AND_NOTB: fire = use_a && !raw_b;
      dtc_pkg::MODE_INSIDE:     fire = in_range;
      dtc_pkg::MODE_OUTSIDE:    fire = bus.valid && !in_range;
      default:                  fire = 1'b0;
    endcase
  end

  // first trigger of a begin trace opens storage
  logic storing;
  always_ff @(posedge aclk) begin
    if (!aresetn || !armed) begin
      seen_a  <= 1'b0;
      storing <= 1'b0;
    end else begin
      if (use_a) seen_a <= 1'b1;
      if (fire && begin_trace) storing <= 1'b1;
    end
  end

  assign trigger_event = armed && (fire || store_evt);
  assign fifo_store    = armed && (event_only ? store_evt
                                  : (begin_trace ? (storing || fire) : bus.valid));

  dtc_fifo_count u_count (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .clear    (ctl_write && w_data[dtc_pkg::BIT_ARM] && !armed),
    .store    (fifo_store),
    .circular (!begin_trace),
    .count    (valid_count),
    .full     (fifo_full)
  );

  // ---- run control ----
  logic run_start;
  logic run_end;
  assign run_start = ctl_write && w_data[dtc_pkg::BIT_ARM] && w_data[dtc_pkg::BIT_ENABLE]
                     && !secured && !armed;
  assign run_end   = armed && ((begin_trace && fifo_full) || (!begin_trace && fire));

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      control <= dtc_pkg::CONTROL_RESET;
    end else if (ctl_write) begin
      control <= w_data[7:0];
      control[dtc_pkg::BIT_ENABLE] <= w_data[dtc_pkg::BIT_ENABLE] && !secured;
      control[dtc_pkg::BIT_ARM]    <= w_data[dtc_pkg::BIT_ARM] && w_data[dtc_pkg::BIT_ENABLE]
                                      && !secured;
    end else begin
      if (secured) control[dtc_pkg::BIT_ENABLE] <= 1'b0;
      if (run_end || secured) control[dtc_pkg::BIT_ARM] <= 1'b0;
    end
  end

  assign armed      = control[dtc_pkg::BIT_ARM] && control[dtc_pkg::BIT_ENABLE];
  assign run_active = armed;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      trigger <= dtc_pkg::TRIGGER_RESET;
    end else if (trg_write && !armed) begin
      trigger <= w_data[7:0] & dtc_pkg::TRIGGER_WRITE_MASK;
    end
  end

  // a run only starts while disarmed and flags only set while armed, so the start clear never meets a set
  always_ff @(posedge aclk) begin
    if (!aresetn || run_start) begin
      flag_a <= 1'b0;
      flag_b <= 1'b0;
    end else if (armed) begin
      if (use_a) flag_a <= 1'b1;
      if (use_b) flag_b <= 1'b1;
    end
  end

  // ---- read channel ----
  logic [7:0] status;
  assign status = {flag_a, flag_b, armed, 1'b0, valid_count};

  assign s_axi_arready = !s_axi_rvalid;
  assign do_read       = s_axi_arvalid && s_axi_arready;
  // the fifo stays frozen while armed so reads cannot disturb capture
  assign fifo_advance  = do_read && s_axi_araddr == dtc_pkg::ADDR_FIFO_LOW && !armed;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= dtc_pkg::RESP_OKAY;
    end else if (do_read) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= reg_mapped(s_axi_araddr) ? dtc_pkg::RESP_OKAY : dtc_pkg::RESP_SLVERR;
      case (s_axi_araddr)
        dtc_pkg::ADDR_CONTROL:  s_axi_rdata <= {24'h000000, control};
        dtc_pkg::ADDR_TRIGGER:  s_axi_rdata <= {24'h000000, trigger};
        dtc_pkg::ADDR_STATUS:   s_axi_rdata <= {24'h000000, status};
        dtc_pkg::ADDR_FIFO_LOW: s_axi_rdata <= {16'h0000, fifo_word};
        default:                s_axi_rdata <= 32'h0000_0000;
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule

/* sim/dtc_trigger_chk.sv */
// port assertions for the debug trigger and capture status block
`timescale 1ns/10ps
module dtc_trigger_chk (
  input wire logic                 aclk,
  input wire logic                 aresetn,
  input wire logic [3:0]           s_axi_awaddr,
  input wire logic                 s_axi_awvalid,
  input wire logic                 s_axi_awready,
  input wire logic [31:0]          s_axi_wdata,
  input wire logic                 s_axi_wvalid,
  input wire logic                 s_axi_wready,
  input wire logic                 s_axi_bvalid,
  input wire logic [3:0]           s_axi_araddr,
  input wire logic                 s_axi_arvalid,
  input wire logic                 s_axi_arready,
  input wire logic                 s_axi_rvalid,
  input wire logic                 s_axi_rready,
  input wire dtc_pkg::dtc_bus_type bus,
  input wire logic                 exec_valid,
  input wire logic                 fifo_store,
  input wire logic                 fifo_advance,
  input wire logic                 trigger_event,
  input wire logic                 run_active
);
  logic [3:0] wa_q;
  logic [7:0] wd_q;
  logic       rd_low;
  // last accepted write address and data, so a response can be tied to its cause
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wa_q <= 4'h0;
      wd_q <= 8'h00;
    end else begin
      if (s_axi_awvalid && s_axi_awready) wa_q <= s_axi_awaddr;
      if (s_axi_wvalid && s_axi_wready) wd_q <= s_axi_wdata[7:0];
    end
  end
  assign rd_low = s_axi_arvalid && s_axi_arready && s_axi_araddr == dtc_pkg::ADDR_FIFO_LOW;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  run_stop_a: assert property (
    s_axi_bvalid && wa_q == dtc_pkg::ADDR_CONTROL && wd_q[7:6] != 2'b11 |-> !run_active)
    else $error("run active after a stop write");
  arm_write_a: assert property (
    $rose(run_active) |-> wa_q == dtc_pkg::ADDR_CONTROL && wd_q[7:6] == 2'b11)
    else $error("run started without an arm write");
  store_armed_a: assert property (fifo_store |-> run_active)
    else $error("fifo store while disarmed");
  adv_idle_a: assert property (fifo_advance |-> rd_low && !run_active)
    else $error("fifo advance without a disarmed low read");
  adv_read_a: assert property (rd_low && !run_active |-> fifo_advance)
    else $error("low read did not advance the fifo");
  trig_cause_a: assert property (trigger_event |-> bus.valid || exec_valid)
    else $error("trigger without a bus cycle or execution");
  rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  rd_done_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read answer held after handshake");
  cover property (trigger_event);
  cover property (fifo_advance);
  cover property ($fell(run_active));
endmodule

bind dtc_trigger dtc_trigger_chk chk (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .bus(bus),
  .exec_valid(exec_valid), .fifo_store(fifo_store), .fifo_advance(fifo_advance),
  .trigger_event(trigger_event), .run_active(run_active)
);

/* sim/dtc_cpu_model.sv */
// processor bus model: replays queued bus cycles and execution events
`timescale 1ns/10ps
module dtc_cpu_model (
  input  wire logic            aclk,
  output dtc_pkg::dtc_bus_type bus,
  output logic                 exec_valid,
  output logic                 exec_taken
);
  typedef struct packed {
    dtc_pkg::dtc_bus_type b;
    logic                 ev;
    logic                 et;
  } dtc_step_type;
  dtc_step_type q[$];
  dtc_step_type s;
  int           n_sent = 0;
  initial bus = '0;
  initial exec_valid = 1'b0;
  initial exec_taken = 1'b0;
  always @(posedge aclk) begin
    s = '0;
    if (q.size() > 0) begin
      s = q.pop_front();
      n_sent <= n_sent + 1;
    end
    // an idle bus shows the inverse of its last value, never a stale copy
    bus <= s.b.valid ? s.b : {1'b0, ~bus.addr, ~bus.data, 1'b0};
    exec_valid <= s.ev;
    exec_taken <= s.ev ? s.et : ~exec_taken;
  end
endmodule

/* sim/dtc_trigger_tb.sv */
// self-checking bench for the debug trigger and capture status block
`timescale 1ns/10ps
module dtc_trigger_tb;
  localparam logic [3:0] CT = dtc_pkg::ADDR_CONTROL;
  localparam logic [3:0] TG = dtc_pkg::ADDR_TRIGGER;
  localparam logic [3:0] ST = dtc_pkg::ADDR_STATUS;
  localparam logic [3:0] FL = dtc_pkg::ADDR_FIFO_LOW;
  logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, secured, fifo_store, fifo_advance;
  logic        trigger_event, run_active, exec_valid, exec_taken;
  logic [3:0]  awaddr, araddr, wstrb;
  logic [31:0] wdata, rdata, rd_v;
  logic [1:0]  bresp, rresp;
  logic [15:0] fifo_word, fw;
  int          n_fail, checked, seed, first, n0;
  dtc_pkg::dtc_bus_type bus;
  dtc_trigger dut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .bus(bus),
    .comp_a_value(16'h1000), .comp_b_value(16'h2000), .exec_valid(exec_valid),
    .exec_taken(exec_taken), .secured(secured), .fifo_word(fifo_word),
    .fifo_store(fifo_store), .fifo_advance(fifo_advance),
    .trigger_event(trigger_event), .run_active(run_active)
  );
  dtc_cpu_model cpu (.aclk(aclk), .bus(bus), .exec_valid(exec_valid), .exec_taken(exec_taken));
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  initial begin
    #400000;
    n_fail = n_fail + 1;
    summarize();
  end
  always @(posedge aclk)
    if (trigger_event === 1'b1 && first < 0) first = cpu.n_sent - 1 - n0;
  // cycle of first trigger for the probe 0800, A/55, 1800, B/55, A/00
  function automatic int exp_first(input logic [3:0] m);
    case (m)
      4'h0, 4'h1, 4'h6, 4'h7: return 1;
      4'h2, 4'h3, 4'h4: return 3;
      4'h5: return 4;
      4'h8: return 0;
      default: return -1;
    endcase
  endfunction
  // only the four word offsets of the map answer okay; every other offset is refused
  function automatic logic [1:0] exp_resp(input logic [3:0] a);
    return (a == CT || a == TG || a == ST || a == FL) ? dtc_pkg::RESP_OKAY : dtc_pkg::RESP_SLVERR;
  endfunction
  task automatic summarize();
    if (n_fail == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checked = checked + 1;
    if (got !== exp) begin
      n_fail = n_fail + 1;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'($random(seed)), d};
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk("bresp", 32'(exp_resp(a)), 32'(bresp));
  endtask
  task automatic rc(input logic [3:0] a, input logic [31:0] exp, input logic [31:0] mask);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rd_v = rdata;
    rready <= 1'b0;
    chk($sformatf("reg %h", a), exp, rd_v & mask);
    chk("rresp", 32'(exp_resp(a)), 32'(rresp));
  endtask
  task automatic push(input logic v, input logic [15:0] a, input logic [7:0] d,
                      input logic f, input logic ev, input logic et);
    cpu.q.push_back({v, a, d, f, ev, et});
  endtask
  task automatic drain();
    while (cpu.q.size() > 0) @(posedge aclk);
    repeat (3) @(posedge aclk);
  endtask
  initial begin
    seed = 32'hF9BCC840;
    {n_fail, checked, n0, first} = '0;
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready, secured} = 6'h00;
    {awaddr, araddr, wstrb, wdata, fifo_word} = '0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    rc(CT, 32'h0, 32'hFF);
    rc(TG, 32'h0, 32'hFF);
    rc(ST, 32'h0, 32'hFF);
    wr(4'h2, 8'hC0);
    rc(4'h2, 32'h0, 32'hFFFFFFFF);
    wr(TG, 8'hFF);
    rc(TG, 32'hCF, 32'hFFFFFFFF);
    wr(ST, 8'hFF);
    rc(ST, 32'h0, 32'hFF);
    wr(CT, 8'hC0);
    rc(ST, 32'h20, 32'hFF);
    wr(TG, 8'h00);
    rc(TG, 32'hCF, 32'hFF);
    wr(CT, 8'h80);
    rc(ST, 32'h0, 32'h20);
    wr(CT, 8'hC0);
    wr(CT, 8'h40);
    rc(ST, 32'h0, 32'h20);
    for (int m = 0; m < 16; m++) begin
      wr(TG, 8'(m));
      wr(CT, 8'hC0);
      n0 = cpu.n_sent;
      first = -1;
      push(1, 16'h0800, 8'h55, 0, 0, 0);
      push(1, 16'h1000, 8'h55, 0, 0, 0);
      push(1, 16'h1800, 8'h55, 0, 0, 0);
      push(1, 16'h2000, 8'h55, 0, 0, 0);
      push(1, 16'h1000, 8'h00, 0, 0, 0);
      drain();
      chk("first trigger", exp_first(4'(m)), first);
      if (m == 0) rc(ST, 32'h80, 32'hA0);
      if (m == 3) rc(ST, 32'h60, 32'h60);
      wr(CT, 8'h80);
    end
    wr(TG, 8'h00);
    wr(CT, 8'hC0);
    repeat (10) push(1, {4'h3, 12'($random(seed))}, 8'($random(seed)), 1'($random(seed)), 0, 0);
    push(1, 16'h1000, 8'h55, 0, 0, 0);
    drain();
    rc(ST, 32'h88, 32'hFF);
    for (int k = 0; k < 3; k++) begin
      fw = 16'($random(seed));
      fifo_word <= fw;
      rc(FL, {16'h0, fw}, 32'hFFFFFFFF);
    end
    rc(ST, 32'h88, 32'hFF);
    wr(TG, 8'h40);
    wr(CT, 8'hC0);
    rc(ST, 32'h20, 32'hFF);
    push(1, 16'h1000, 8'h55, 0, 0, 0);
    repeat (2) push(1, 16'h3000, 8'($random(seed)), 0, 0, 0);
    drain();
    rc(ST, 32'hA0, 32'hE0);
    repeat (10) push(1, 16'h3000, 8'($random(seed)), 0, 0, 0);
    drain();
    rc(ST, 32'h88, 32'hFF);
    wr(TG, 8'h80);
    wr(CT, 8'hC0);
    push(1, 16'h1000, 8'h55, 1, 0, 0);
    push(0, 16'h0000, 8'h00, 0, 1, 0);
    drain();
    rc(ST, 32'h20, 32'h20);
    push(1, 16'h1000, 8'h55, 1, 0, 0);
    push(0, 16'h0000, 8'h00, 0, 1, 1);
    drain();
    rc(ST, 32'h00, 32'h20);
    secured <= 1'b1;
    wr(CT, 8'hC0);
    rc(CT, 32'h0, 32'h80);
    rc(ST, 32'h0, 32'h20);
    summarize();
  end
endmodule
